// >>> inc/cwr_pkg.sv
/*
 * shared constants and types of the selective-wake clock and data recovery block.
 * assumes a single 10 mhz core clock; all configuration arrives as plain ports.
 */
package cwr_pkg;

	// ********************************************************************
	// clock and timing
	// ********************************************************************
	localparam int CLK_FREQ_MHZ  = 10;
	localparam int BIAS_MAX_US   = 250;
	localparam int BIAS_MAX_CYC  = BIAS_MAX_US * CLK_FREQ_MHZ;
	localparam int WAKE_MAX_US   = 100;
	localparam int WAKE_MAX_CYC  = WAKE_MAX_US * CLK_FREQ_MHZ;
	localparam int BIT_MIN_US    = 1;
	localparam int BIT_MIN_CYC   = BIT_MIN_US * CLK_FREQ_MHZ;
	localparam int INT_PULSE_US  = 20;
	localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_FREQ_MHZ;

	// ********************************************************************
	// bit timing
	// ********************************************************************
	localparam logic [5:0] SAMPLE_POINT_DEFAULT = 6'h33;
	localparam int         SAMPLE_SHIFT         = 6;
	localparam int         LEN_W                = 8;
	localparam int         PRE_W                = 3;
	localparam int         FILT_W               = 11;
	localparam int         FILT_SHIFT           = 8;
	localparam logic [7:0] FILT_SLOW_NUM        = 8'h1a;
	localparam logic [7:0] FILT_FAST_NUM        = 8'h0d;

	// ********************************************************************
	// types
	// ********************************************************************
	typedef struct packed {
		logic       recovery_enable;
		logic [1:0] recovery_clock_select;
		logic [5:0] sample_point_setting;
		logic [7:0] limit_low;
		logic [7:0] limit_high;
		logic       frame_receiver_select;
		logic       fd_tolerant_enable;
		logic       fast_data_glitch_filter;
	} cwr_cfg_s;

	typedef enum logic [1:0] {
		REC_OFF,
		REC_SEEK,
		REC_TRACK
	} cwr_rec_e;

	typedef enum logic {
		WAKE_IDLE,
		WAKE_INT
	} cwr_wake_e;

endpackage

// >>> hw/cwr_sync.sv
/*
 * two-stage synchroniser for asynchronous receive pins.
 * assumes the pin idles at RST_VAL; the clock enable freezes both stages.
 */
`timescale 1ns/1ps
module cwr_sync #(
	parameter int   W       = 1,
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			meta   <= {W{RST_VAL}};
			o_sync <= {W{RST_VAL}};
		end else if (i_ce) begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule

// >>> hw/cwr_top.sv
/*
 * clock and data recovery, receive path selection, fd glitch filter and wake
 * signalling for the selective-wake frame decoder.
 * assumes the frame decoder on the same clock pulses the wake events and that
 * the host keeps the configuration stable while recovery is enabled.
 */
//
// Functional notes
// - with recovery on, bus edges retune the bit length; off, it stays at start
// - reaching a limit discards measurements and reloads the sample-point start value
// - bus biasing applied within 250 us in partial-network operation
// - wake signalled within 100 us after a valid pattern or frame
// - wake timing starts at last dominant end or crc delimiter end
// - stop mode wakes by interrupt low; sleep wakes by regulator ramp-up
// - decoder supports bit times down to 1 us
// - 2 mbit data: ignore dominant up to 5%, detect from 17.5%
// - 5 mbit data: ignore dominant up to 2.5%, detect from 8.75%
// - tolerance holds for arbitration up to 500 kbps until fdf
// - dominant filter applies only with the normal-mode receiver selected
// - frame receiver select picks the path feeding the decoder
// - sample point and clock select together set quanta per bit
`timescale 1ns/1ps
module cwr_top
	import cwr_pkg::*;
#(
	parameter int INT_PULSE = INT_PULSE_CYC
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire cwr_cfg_s         i_cfg,
	input  wire logic             i_rx_normal,
	input  wire logic             i_rx_wake,
	input  wire logic             i_pn_active,
	input  wire logic             i_stop_mode,
	input  wire logic             i_sleep_mode,
	input  wire logic             i_wake_pattern_end,
	input  wire logic             i_wake_frame_end,
	output logic                  o_rx_decoder,
	output logic      [LEN_W-1:0] o_bit_length,
	output logic      [LEN_W-1:0] o_sample_point,
	output logic                  o_limit_hit,
	output logic                  o_recovery_active,
	output logic                  o_bus_bias,
	output logic                  o_interrupt_out_n,
	output logic                  o_main_regulator_output
);

	// ********************************************************************
	// receive pins
	// ********************************************************************
	logic [1:0] rx_sync;

	cwr_sync #(
		.W       (2),
		.RST_VAL (1'b1)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_async    ({i_rx_normal, i_rx_wake}),
		.o_sync     (rx_sync)
	);

	wire rx_normal_s = rx_sync[1];
	wire rx_wake_s   = rx_sync[0];
	wire rx_sel      = i_cfg.frame_receiver_select ? rx_normal_s : rx_wake_s;

	// ********************************************************************
	// bit timing decode
	// ********************************************************************
	cwr_rec_e          rec_state;
	cwr_rec_e          next_rec_state;
	logic [PRE_W-1:0]  pre_cnt;
	logic [LEN_W-1:0]  tick_cnt;
	logic [LEN_W-1:0]  next_bit_length;
	logic              next_limit_hit;

	// start value: sample point is ~80% of the bit, so the bit is 5/4 of it
	wire [LEN_W-1:0] start_len = LEN_W'(i_cfg.sample_point_setting)
		+ LEN_W'(i_cfg.sample_point_setting >> 2);
	wire [PRE_W-1:0] pre_mask  = PRE_W'(~(3'h7 << i_cfg.recovery_clock_select));
	wire             tick      = (pre_cnt & pre_mask) == pre_mask;
	wire [LEN_W-1:0] half_len  = o_bit_length >> 1;
	wire [LEN_W:0]   win_hi    = {1'b0, o_bit_length} + {1'b0, half_len};
	wire             one_bit   = (tick_cnt >= half_len) && ({1'b0, tick_cnt} < win_hi);
	wire [LEN_W-1:0] len_up    = o_bit_length + 8'h01;
	wire [LEN_W-1:0] len_dn    = o_bit_length - 8'h01;
	wire [LEN_W-1:0] len_adj   = (tick_cnt > o_bit_length) ? len_up :
		(tick_cnt < o_bit_length) ? len_dn : o_bit_length;
	wire             at_limit  = (len_adj >= i_cfg.limit_high) || (len_adj <= i_cfg.limit_low);
	wire [13:0]      sp_prod   = o_bit_length * i_cfg.sample_point_setting;
	wire [LEN_W-1:0] next_sp   = sp_prod[SAMPLE_SHIFT +: LEN_W];

	// ********************************************************************
	// fast-data glitch filter
	// ********************************************************************
	logic [FILT_W-1:0] dom_run;

	wire              filt_on  = i_cfg.fd_tolerant_enable && i_cfg.frame_receiver_select;
	wire [FILT_W-1:0] bit_clk  = FILT_W'({3'h0, o_bit_length} << i_cfg.recovery_clock_select);
	// about 5% of the bit in 5 mbit mode, about 10% in 2 mbit mode
	wire [7:0]        filt_num = i_cfg.fast_data_glitch_filter ? FILT_FAST_NUM : FILT_SLOW_NUM;
	wire [18:0]       thr_prod = bit_clk * filt_num;
	wire [FILT_W-1:0] thr_raw  = thr_prod[FILT_SHIFT +: FILT_W];
	// at the shortest bit the threshold still needs one full cycle
	wire [FILT_W-1:0] dom_thr  = (thr_raw == '0) ? FILT_W'(1) : thr_raw;
	wire              dom_sat  = &dom_run;
	wire [FILT_W-1:0] next_dom_run = rx_sel ? '0 : (dom_sat ? dom_run : dom_run + 11'h001);
	wire              next_rx  = filt_on ? (rx_sel || (next_dom_run < dom_thr)) : rx_sel;
	wire              rx_edge  = next_rx != o_rx_decoder;

	// ********************************************************************
	// recovery control
	// ********************************************************************
	always_comb begin
		next_rec_state  = rec_state;
		next_bit_length = o_bit_length;
		next_limit_hit  = 1'b0;
		unique case (rec_state)
			REC_OFF: begin
				next_bit_length = start_len;
				if (i_cfg.recovery_enable)
					next_rec_state = REC_SEEK;
			end
			REC_SEEK: begin
				if (rx_edge)
					next_rec_state = REC_TRACK;
			end
			REC_TRACK: begin
				if (rx_edge && one_bit) begin
					if (at_limit) begin
						next_bit_length = start_len;
						next_limit_hit  = 1'b1;
						next_rec_state  = REC_SEEK;
					end else begin
						next_bit_length = len_adj;
					end
				end
			end
		endcase
		if (!i_cfg.recovery_enable) begin
			next_rec_state  = REC_OFF;
			next_bit_length = start_len;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rec_state         <= REC_OFF;
			o_bit_length      <= '0;
			o_limit_hit       <= 1'b0;
			o_recovery_active <= 1'b0;
			o_sample_point    <= '0;
		end else if (i_ce) begin
			rec_state         <= next_rec_state;
			o_bit_length      <= next_bit_length;
			o_limit_hit       <= next_limit_hit;
			o_recovery_active <= next_rec_state == REC_TRACK;
			o_sample_point    <= next_sp;
		end
	end

	// interval counter in selected-clock ticks, restarted by every edge
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pre_cnt  <= '0;
			tick_cnt <= '0;
		end else if (i_ce) begin
			pre_cnt <= rx_edge ? '0 : pre_cnt + 3'h1;
			if (rx_edge)
				tick_cnt <= '0;
			else if (tick && !(&tick_cnt))
				tick_cnt <= tick_cnt + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			dom_run      <= '0;
			o_rx_decoder <= 1'b1;
		end else if (i_ce) begin
			dom_run      <= next_dom_run;
			o_rx_decoder <= next_rx;
		end
	end

	// ********************************************************************
	// wake signalling and bus bias
	// ********************************************************************
	cwr_wake_e  wake_state;
	logic [7:0] int_cnt;
	logic       woke;

	wire wake_evt  = i_wake_pattern_end || i_wake_frame_end;
	wire wake_stop = wake_evt && i_stop_mode;
	wire wake_slp  = wake_evt && i_sleep_mode;
	// leaving sleep mode clears the flag even with a new wake in that cycle
	wire next_woke = wake_slp || (woke && i_sleep_mode);

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wake_state        <= WAKE_IDLE;
			int_cnt           <= '0;
			o_interrupt_out_n <= 1'b1;
		end else if (i_ce) begin
			unique case (wake_state)
				WAKE_IDLE: begin
					if (wake_stop) begin
						wake_state        <= WAKE_INT;
						int_cnt           <= 8'(INT_PULSE - 1);
						o_interrupt_out_n <= 1'b0;
					end
				end
				WAKE_INT: begin
					if (wake_stop) begin
						int_cnt <= 8'(INT_PULSE - 1);
					end else if (int_cnt == 8'h00) begin
						wake_state        <= WAKE_IDLE;
						o_interrupt_out_n <= 1'b1;
					end else begin
						int_cnt <= int_cnt - 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			woke                    <= 1'b0;
			o_main_regulator_output <= 1'b1;
			o_bus_bias              <= 1'b0;
		end else if (i_ce) begin
			woke                    <= next_woke;
			o_main_regulator_output <= !i_sleep_mode || next_woke;
			o_bus_bias              <= i_pn_active;
		end
	end

	// ********************************************************************
	// assertions
	// ********************************************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	AST_DISABLED_START: assert property (
		(i_ce && !i_cfg.recovery_enable) |=> o_bit_length == $past(start_len))
		else $error("bit length not at start value while recovery is off");

	AST_LIMIT_RELOAD: assert property (
		(i_ce && rec_state == REC_TRACK && i_cfg.recovery_enable && rx_edge && one_bit
			&& at_limit) |=> (o_limit_hit && o_bit_length == $past(start_len)
			&& !o_recovery_active))
		else $error("limit reached without reload of start value");

	AST_STEP_ONE: assert property (
		(i_ce && rec_state == REC_TRACK && i_cfg.recovery_enable && !(rx_edge && at_limit))
		|=> (o_bit_length == $past(o_bit_length) || o_bit_length == $past(len_up)
			|| o_bit_length == $past(len_dn)))
		else $error("bit length moved by more than one tick");

	AST_RX_WAKE_PATH: assert property (
		(i_ce && !i_cfg.frame_receiver_select) |=> o_rx_decoder == $past(rx_wake_s))
		else $error("wake receiver path not passed to decoder");

	// glitch bounds scaled by 80: ignore up to 4 or 2 parts, detect from 14 or 7 parts
	wire [17:0] run_x80 = 18'(next_dom_run) * 18'h50;
	wire [17:0] ign_x80 = 18'(bit_clk) * (i_cfg.fast_data_glitch_filter ? 18'h2 : 18'h4);
	wire [17:0] det_x80 = 18'(bit_clk) * (i_cfg.fast_data_glitch_filter ? 18'h7 : 18'he);

	AST_GLITCH_LEN: assert property (
		(i_ce && filt_on && o_rx_decoder && !next_rx) |-> run_x80 > ign_x80)
		else $error("dominant passed within the ignored glitch length");

	AST_GLITCH_DETECT: assert property (
		(i_ce && filt_on && bit_clk != '0 && run_x80 >= det_x80) |-> !next_rx)
		else $error("dominant run beyond the detect length not passed");

	AST_UNFILTERED: assert property (
		(i_ce && !filt_on) |=> o_rx_decoder == $past(rx_sel))
		else $error("filter active with wake receiver or fd mode off");

	AST_BIAS: assert property (
		(i_ce && i_pn_active) ##1 i_ce |-> ##[0:1] o_bus_bias)
		else $error("bus bias late in partial-network operation");

	AST_WAKE_INT: assert property (
		(i_ce && wake_stop) |=> !o_interrupt_out_n)
		else $error("stop-mode wake did not pull interrupt low");

	AST_INT_HOLD: assert property (
		(i_ce && $fell(o_interrupt_out_n)) |-> (!o_interrupt_out_n) [*8])
		else $error("wake interrupt released too early");

	AST_WAKE_REG: assert property (
		(i_ce && wake_slp) |=> (o_main_regulator_output && woke))
		else $error("sleep wake did not ramp the regulator");

	COV_LIMIT: cover property (o_limit_hit);
	COV_TRACK_ADJ: cover property (o_recovery_active ##1 $changed(o_bit_length));
	COV_STOP_WAKE: cover property ($fell(o_interrupt_out_n));
	COV_SLEEP_WAKE: cover property (i_sleep_mode && $rose(o_main_regulator_output));

endmodule

// >>> tb/cwr_bus_node.sv
/*
 * bus node model driving both receive pins of the recovery block.
 * assumes the bench calls its tasks; pins idle recessive between frames.
 */
`timescale 1ns/1ps
module cwr_bus_node (
	input  wire logic i_core_clk,
	output logic      o_rx_normal,
	output logic      o_rx_wake
);
	initial begin
		o_rx_normal = 1'b1;
		o_rx_wake   = 1'b1;
	end

	// ********************************************************************
	// traffic
	// ********************************************************************
	// one bus edge every period cycles; an even count ends recessive
	task automatic edges(input int count, input int period);
		for (int i = 0; i < count; i++) begin
			repeat (period) @(negedge i_core_clk);
			o_rx_normal = ~o_rx_normal;
		end
	endtask

	// single dominant pulse of len cycles on the chosen path
	task automatic pulse(input logic wake_path, input int len);
		@(negedge i_core_clk);
		if (wake_path) o_rx_wake = 1'b0;
		else o_rx_normal = 1'b0;
		repeat (len) @(negedge i_core_clk);
		o_rx_normal = 1'b1;
		o_rx_wake   = 1'b1;
	endtask
endmodule

// >>> tb/can_selective_wake_cdr_tb_top.sv
/*
 * self-checking bench of the recovery block with a bus node model.
 * assumes a short interrupt pulse parameter; clock enable drops once to check the freeze.
 */
`timescale 1ns/1ps
module can_selective_wake_cdr_tb_top;
	import cwr_pkg::*;

	localparam int PULSE = 16;
	logic             i_core_clk = 1'b0;
	logic             i_rst      = 1'b1;
	logic             ce         = 1'b1;
	cwr_cfg_s         cfg        = '0;
	logic             rx_normal, rx_wake;
	logic             pn = 1'b0, stop = 1'b0, sleep = 1'b0, pat = 1'b0, frm = 1'b0;
	logic             rx_dec, hit, active, bias, int_n, reg_on;
	logic [LEN_W-1:0] bit_len, samp;
	logic             seen_dom = 1'b0, seen_hit = 1'b0;
	int               num_errors = 0, num_checks = 0, cycles = 0;
	int               per;
	logic [5:0]       sp_tab [4] = '{6'h33, 6'h08, 6'h3f, 6'h20};

	initial forever #50 i_core_clk = ~i_core_clk;

	cwr_bus_node i_node (.i_core_clk(i_core_clk), .o_rx_normal(rx_normal), .o_rx_wake(rx_wake));

	cwr_top #(.INT_PULSE(PULSE)) i_dut (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(ce), .i_cfg(cfg),
		.i_rx_normal(rx_normal), .i_rx_wake(rx_wake), .i_pn_active(pn),
		.i_stop_mode(stop), .i_sleep_mode(sleep), .i_wake_pattern_end(pat),
		.i_wake_frame_end(frm), .o_rx_decoder(rx_dec), .o_bit_length(bit_len),
		.o_sample_point(samp), .o_limit_hit(hit), .o_recovery_active(active),
		.o_bus_bias(bias), .o_interrupt_out_n(int_n), .o_main_regulator_output(reg_on)
	);

	// ********************************************************************
	// monitors and helpers
	// ********************************************************************
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (rx_dec === 1'b0) seen_dom <= 1'b1;
		if (hit === 1'b1) seen_hit <= 1'b1;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	function automatic logic [7:0] f_start(input logic [5:0] sp);
		return 8'(sp) + 8'(sp >> 2);
	endfunction

	function automatic logic [7:0] f_samp(input logic [7:0] len, input logic [5:0] sp);
		return 8'((16'(len) * 16'(sp)) >> 6);
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask

	// recovery off, settings, then recovery enable set from en (transceiver assumed off)
	task automatic setup(input logic [5:0] sp, input logic [7:0] lo, input logic [7:0] hi,
			input logic en);
		@(negedge i_core_clk);
		cfg.recovery_enable = 1'b0;
		idle(2);
		cfg.recovery_clock_select = 2'h0;
		cfg.sample_point_setting  = sp;
		cfg.limit_low             = lo;
		cfg.limit_high            = hi;
		idle(2);
		cfg.recovery_enable = en;
		idle(3);
	endtask

	task automatic glitch(input logic path, input int len, input logic exp);
		seen_dom = 1'b0;
		i_node.pulse(path, len);
		idle(12);
		check(8'(seen_dom), 8'(exp));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ********************************************************************
	// tests
	// ********************************************************************
	initial begin
		void'($urandom(32'h20cd));
		idle(3);
		check(8'({int_n, reg_on, rx_dec, bias, active, hit}), 8'h38);
		i_rst = 1'b0;
		$display("test reset done");

		foreach (sp_tab[i]) begin
			setup(sp_tab[i], 8'h01, 8'hfe, 1'b0);
			check(bit_len, f_start(sp_tab[i]));
			check(samp, f_samp(f_start(sp_tab[i]), sp_tab[i]));
		end
		$display("test start value done");

		cfg.frame_receiver_select = 1'b1;
		setup(6'h33, 8'h10, 8'hf0, 1'b1);
		per = $urandom_range(72, 80);
		i_node.edges(5, per);
		i_node.edges(3, 50);
		idle(6);
		// first edge starts timing, four long intervals step up, three short ones step down
		check(bit_len, 8'd64);
		check(samp, f_samp(8'd64, 6'h33));
		check(8'(active), 8'h01);
		setup(6'h33, 8'h10, 8'hf0, 1'b0);
		check(bit_len, 8'd63);
		ce = 1'b0;
		cfg.sample_point_setting = 6'h20;
		idle(3);
		check(bit_len, 8'd63);
		ce = 1'b1;
		idle(2);
		check(bit_len, f_start(6'h20));
		$display("test tracking done");

		setup(6'h33, 8'h10, 8'd66, 1'b1);
		seen_hit = 1'b0;
		i_node.edges(4, 70);
		idle(6);
		check(8'(seen_hit), 8'h01);
		check(bit_len, 8'd63);
		check(8'(active), 8'h00);
		$display("test limit done");

		setup(6'h33, 8'h10, 8'hf0, 1'b0);
		cfg.frame_receiver_select = 1'b0;
		glitch(1'b1, 3, 1'b1);
		glitch(1'b0, 20, 1'b0);
		cfg.frame_receiver_select = 1'b1;
		cfg.fd_tolerant_enable    = 1'b1;
		glitch(1'b1, 20, 1'b0);
		glitch(1'b0, 3, 1'b0);
		glitch(1'b0, 11, 1'b1);
		cfg.fast_data_glitch_filter = 1'b1;
		glitch(1'b0, 1, 1'b0);
		glitch(1'b0, 6, 1'b1);
		cfg.recovery_clock_select = 2'h1;
		glitch(1'b0, 3, 1'b0);
		glitch(1'b0, 12, 1'b1);
		$display("test filter done");

		pn = 1'b1;
		idle(BIAS_MAX_CYC);
		check(8'(bias), 8'h01);
		stop = 1'b1;
		pat  = 1'b1;
		idle(1);
		pat = 1'b0;
		for (int i = 0; i < WAKE_MAX_CYC && int_n !== 1'b0; i++) idle(1);
		check(8'(int_n), 8'h00);
		idle(PULSE - 2);
		check(8'(int_n), 8'h00);
		idle(6);
		check(8'(int_n), 8'h01);
		stop  = 1'b0;
		sleep = 1'b1;
		idle(4);
		check(8'(reg_on), 8'h00);
		frm = 1'b1;
		idle(1);
		frm = 1'b0;
		for (int i = 0; i < WAKE_MAX_CYC && reg_on !== 1'b1; i++) idle(1);
		check(8'(reg_on), 8'h01);
		$display("test wake done");
		print_verdict();
	end
endmodule
